// ### hw/ftb_cfg.svh
// Purpose: constants of the four-timer time base: offsets, fields, resets, counts
// Assumes: Avalon byte address = 4 * register index; data in bits 7:0
// Notes: included by its bare name from every design file that needs it
`ifndef FTB_CFG_SVH
`define FTB_CFG_SVH

// register indices (byte address is four times these)
`define FTB_IDX_CTRL 6'h05
`define FTB_IDX_A_LO 6'h0b
`define FTB_IDX_A_HI 6'h0c
`define FTB_IDX_FLAGS 6'h10
`define FTB_IDX_ENABLE 6'h11
`define FTB_IDX_B 6'h12
`define FTB_IDX_C 6'h13
`define FTB_IDX_PER_B 6'h14
`define FTB_IDX_PER_C 6'h15
`define FTB_IDX_D_LO 6'h16
`define FTB_IDX_D_HI 6'h17
`define FTB_IDX_PER_D_LO 6'h18
`define FTB_IDX_PER_D_HI 6'h19
`define FTB_IDX_CFG 6'h1a

// timer_zero_control fields
`define FTB_CTRL_INT_EDGE 7
`define FTB_CTRL_CNT_EDGE 6
`define FTB_CTRL_SRC 5
`define FTB_CTRL_PS_HI 4
`define FTB_CTRL_PS_LO 1
`define FTB_CTRL_RESET 8'h00
`define FTB_CTRL_WMASK 8'hfe

// flag and enable register fields
`define FTB_FLG_A 0
`define FTB_FLG_EDGE 1
`define FTB_FLG_INT 2
`define FTB_FLG_B 3
`define FTB_FLG_C 4
`define FTB_FLG_D 5
`define FTB_FLG_CAP 6
`define FTB_FLG_RESET 7'h00

// timer configuration fields
`define FTB_CFG_B_RUN 0
`define FTB_CFG_C_RUN 1
`define FTB_CFG_B_EXT 2
`define FTB_CFG_C_EXT 3
`define FTB_CFG_JOIN 4
`define FTB_CFG_D_RUN 5
`define FTB_CFG_D_EXT 6
`define FTB_CFG_CAP4 7
`define FTB_CFG_RESET 8'h00

// other reset values and counts
`define FTB_PER_RESET 8'hff
`define FTB_PER_D_RESET 16'hffff
`define FTB_INSN_LAST 2'h3

`endif

// ### hw/ftb_period_timer.sv
// Purpose: 8-bit up counter with its own period register
// Assumes: caller decides when to count and when to wrap
// Notes: a write to the count wins over clear and increment
`include "ftb_cfg.svh"

module ftb_period_timer import ftb_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // count control
  input wire logic inc,
  input wire logic clr,
  // software writes
  input wire logic cntWr,
  input wire logic perWr,
  input wire logic [7:0] wrData,
  // state
  output ftb_byte_t count,
  output ftb_byte_t period,
  output logic atMatch
);
  assign atMatch = (count == period);

  // counter: write, wrap to zero, or step
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
    end else if (cntWr) begin
      count <= wrData;
    end else if (clr) begin
      count <= 8'h00;
    end else if (inc) begin
      count <= count + 8'h01;
    end
  end

  // period register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      period <= `FTB_PER_RESET;
    end else if (perWr) begin
      period <= wrData;
    end
  end
endmodule // ftb_period_timer

// ### hw/ftb_pkg.sv
// Purpose: shared types of the four-timer time base
// Assumes: numeric constants live in ftb_cfg.svh
// Notes: bus slave state is one-hot
package ftb_pkg;
  typedef logic [7:0] ftb_byte_t;
  typedef logic [15:0] ftb_word_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ftb_bus_e;
endpackage

// ### hw/ftb_prescaler.sv
// Purpose: 8-bit event prescaler with power-of-two ratio select
// Assumes: countEn is a one-cycle pulse per input event
// Notes: count content is not readable; clear restarts the ratio
module ftb_prescaler import ftb_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // control
  input wire logic countEn,
  input wire logic clear,
  input wire logic [3:0] sel,
  // output pulse, one per ratio events
  output logic tick
);
  ftb_byte_t countR; // events seen in this ratio
  ftb_byte_t mask; // ratio minus one
  logic full; // last event of the ratio

  // code 1xxx saturates to 1:256
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_mask
      assign mask[i] = sel[3] | (sel[2:0] > 3'(i));
    end
  endgenerate

  assign full = ((countR & mask) == mask);
  assign tick = countEn & full & ~clear;

  // event counter, cleared by software writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      countR <= 8'h00;
    end else if (clear) begin
      countR <= 8'h00;
    end else if (countEn) begin
      countR <= full ? 8'h00 : countR + 8'h01;
    end
  end

  a_clear_empties: assert property (@(posedge mclk) disable iff (!reset_n)
    clear |=> countR == 8'h00) else $error("prescaler not cleared");
  a_ratio_one: assert property (@(posedge mclk) disable iff (!reset_n)
    sel == 4'h0 && countEn && !clear |-> tick) else $error("1:1 ratio lost");
endmodule // ftb_prescaler

// ### hw/ftb_top.sv
// Purpose: four timers (a, b, c, d) behind an Avalon-MM register slave
// Assumes: all pins synchronous to mclk; bus answers in the second cycle
// Notes: only byte lane 0 carries data; unmapped reads return zero
//
// The implementer's own choice: the Avalon-MM slave port.
`include "ftb_cfg.svh"

module ftb_top import ftb_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // timer pins
  input wire logic timer0ClockPin,
  input wire logic extIntPin,
  input wire logic sharedExtClockPin,
  input wire logic counterDClockPin,
  input wire logic captureTwoPin,
  // interrupt side
  input wire logic counterAVectorAck,
  output logic intRequest
);
  // bus slave state
  ftb_bus_e busR; // one-hot slave state
  ftb_bus_e busNxt;
  logic [5:0] regIdx; // word index of the access
  logic wrOk; // write takes effect this edge
  logic rdTake; // read data captured this edge
  ftb_byte_t wrByte; // lane 0 write data
  ftb_byte_t rdMux; // selected read byte

  // software registers
  ftb_byte_t timerZeroControlR; // timer_zero_control
  ftb_byte_t cfgR; // timer b/c/d configuration
  logic [6:0] flagsR; // sticky event flags
  logic [6:0] flagsNxt;
  logic [6:0] enableR; // interrupt enables
  logic [6:0] flagSet; // events this cycle
  logic [6:0] flagClr; // clears this cycle

  // write strobes per register
  logic wrCtrl, wrALo, wrAHi, wrFlags, wrEnable, wrCfg;
  logic wrB, wrC, wrPerB, wrPerC, wrDLo, wrDHi, wrPerDLo, wrPerDHi;

  // pin history for edge detection
  logic t0PrevR, intPrevR, sharedPrevR, dPinPrevR, capPrevR;

  // instruction clock divider
  logic [1:0] insnDivR;
  logic insnTick; // one pulse per four mclk

  // counter_a path
  ftb_byte_t counterALowR, counterAHighR;
  logic srcInternal; // count_source_select
  logic t0Edge; // selected timer0ClockPin edge
  logic psEn, psTick; // prescaler in and out
  logic wrA; // either byte written
  logic psToggleR; // prescaler output as a level
  logic syncOneR, syncTwoR, syncThreeR; // resynchroniser
  logic incA; // counter_a step
  logic overflowA;

  // counter_b/c path
  logic sharedFall; // falling edge of shared pin
  logic tickB, tickC, incB, incC, clrB, clrC;
  logic joinMode, wrap16;
  ftb_byte_t counterB, counterC, periodB, periodC;
  logic matchB, matchC;

  // counter_d path
  ftb_word_t counterDR, periodDR;
  logic tickD, incD, wrapD, capMode, capRise;

  // register decode
  assign regIdx = address[7:2];
  assign wrByte = writedata[7:0];
  assign wrOk = write & (busR == BUS_ACK) & byteenable[0];
  assign rdTake = read & (busR == BUS_IDLE);
  assign wrCtrl = wrOk & (regIdx == `FTB_IDX_CTRL);
  assign wrALo = wrOk & (regIdx == `FTB_IDX_A_LO);
  assign wrAHi = wrOk & (regIdx == `FTB_IDX_A_HI);
  assign wrFlags = wrOk & (regIdx == `FTB_IDX_FLAGS);
  assign wrEnable = wrOk & (regIdx == `FTB_IDX_ENABLE);
  assign wrB = wrOk & (regIdx == `FTB_IDX_B);
  assign wrC = wrOk & (regIdx == `FTB_IDX_C);
  assign wrPerB = wrOk & (regIdx == `FTB_IDX_PER_B);
  assign wrPerC = wrOk & (regIdx == `FTB_IDX_PER_C);
  assign wrDLo = wrOk & (regIdx == `FTB_IDX_D_LO);
  assign wrDHi = wrOk & (regIdx == `FTB_IDX_D_HI);
  assign wrPerDLo = wrOk & (regIdx == `FTB_IDX_PER_D_LO);
  assign wrPerDHi = wrOk & (regIdx == `FTB_IDX_PER_D_HI);
  assign wrCfg = wrOk & (regIdx == `FTB_IDX_CFG);

  // read select; unmapped indices read zero
  assign rdMux =
    (regIdx == `FTB_IDX_CTRL) ? timerZeroControlR :
    (regIdx == `FTB_IDX_A_LO) ? counterALowR :
    (regIdx == `FTB_IDX_A_HI) ? counterAHighR :
    (regIdx == `FTB_IDX_FLAGS) ? {1'b0, flagsR} :
    (regIdx == `FTB_IDX_ENABLE) ? {1'b0, enableR} :
    (regIdx == `FTB_IDX_B) ? counterB :
    (regIdx == `FTB_IDX_C) ? counterC :
    (regIdx == `FTB_IDX_PER_B) ? periodB :
    (regIdx == `FTB_IDX_PER_C) ? periodC :
    (regIdx == `FTB_IDX_D_LO) ? counterDR[7:0] :
    (regIdx == `FTB_IDX_D_HI) ? counterDR[15:8] :
    (regIdx == `FTB_IDX_PER_D_LO) ? periodDR[7:0] :
    (regIdx == `FTB_IDX_PER_D_HI) ? periodDR[15:8] :
    (regIdx == `FTB_IDX_CFG) ? cfgR : 8'h00;

  // every access waits exactly one cycle; keeps decode off the answer path
  assign waitrequest = (read | write) & (busR == BUS_IDLE);

  // slave state: idle, then one answer cycle
  always_comb begin
    case (busR)
      BUS_IDLE: busNxt = (read | write) ? BUS_ACK : BUS_IDLE;
      BUS_ACK: busNxt = BUS_IDLE;
      default: busNxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busR <= BUS_IDLE;
    end else begin
      busR <= busNxt;
    end
  end

  // read data captured at the request edge, stands through the answer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h00000000;
    end else if (rdTake) begin
      readdata <= {24'h000000, rdMux};
    end
  end

  // control and configuration registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timerZeroControlR <= `FTB_CTRL_RESET;
      cfgR <= `FTB_CFG_RESET;
      enableR <= `FTB_FLG_RESET;
    end else begin
      if (wrCtrl) timerZeroControlR <= wrByte & `FTB_CTRL_WMASK;
      if (wrCfg) cfgR <= wrByte;
      if (wrEnable) enableR <= wrByte[6:0];
    end
  end

  // pin history, one flop per pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      t0PrevR <= 1'b0;
      intPrevR <= 1'b0;
      sharedPrevR <= 1'b0;
      dPinPrevR <= 1'b0;
      capPrevR <= 1'b0;
    end else begin
      t0PrevR <= timer0ClockPin;
      intPrevR <= extIntPin;
      sharedPrevR <= sharedExtClockPin;
      dPinPrevR <= counterDClockPin;
      capPrevR <= captureTwoPin;
    end
  end

  // instruction clock: one tick every fourth mclk
  assign insnTick = (insnDivR == `FTB_INSN_LAST);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      insnDivR <= 2'h0;
    end else begin
      insnDivR <= insnDivR + 2'h1;
    end
  end

  // counter_a clock source and edge choice
  assign srcInternal = timerZeroControlR[`FTB_CTRL_SRC];
  assign t0Edge = timerZeroControlR[`FTB_CTRL_CNT_EDGE] ?
    (timer0ClockPin & ~t0PrevR) : (~timer0ClockPin & t0PrevR);
  assign psEn = srcInternal ? insnTick : t0Edge;
  assign wrA = wrALo | wrAHi;

  ftb_prescaler u_prescaler (
    .mclk(mclk),
    .reset_n(reset_n),
    .countEn(psEn),
    .clear(wrA),
    .sel(timerZeroControlR[`FTB_CTRL_PS_HI:`FTB_CTRL_PS_LO]),
    .tick(psTick)
  );

  // external path: prescaler output becomes a level, then resynchronised
  // so the counter sees one clean step per prescaled pin period
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      psToggleR <= 1'b0;
      syncOneR <= 1'b0;
      syncTwoR <= 1'b0;
      syncThreeR <= 1'b0;
    end else begin
      if (psTick && !srcInternal) psToggleR <= ~psToggleR;
      syncOneR <= psToggleR;
      syncTwoR <= syncOneR;
      syncThreeR <= syncTwoR;
    end
  end

  assign incA = srcInternal ? psTick : (syncTwoR ^ syncThreeR);
  assign overflowA = incA & ~wrA & ({counterAHighR, counterALowR} == 16'hffff);

  // counter_a bytes; a written byte skips its step that cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counterALowR <= 8'h00;
      counterAHighR <= 8'h00;
    end else begin
      if (wrALo) counterALowR <= wrByte;
      else if (incA) counterALowR <= counterALowR + 8'h01;
      if (wrAHi) counterAHighR <= wrByte;
      else if (incA && !wrALo && counterALowR == 8'hff)
        counterAHighR <= counterAHighR + 8'h01;
    end
  end

  // counter_b/c clocking and period compare
  assign sharedFall = ~sharedExtClockPin & sharedPrevR;
  assign joinMode = cfgR[`FTB_CFG_JOIN];
  assign tickB = cfgR[`FTB_CFG_B_EXT] ? sharedFall : insnTick;
  assign tickC = cfgR[`FTB_CFG_C_EXT] ? sharedFall : insnTick;
  assign incB = cfgR[`FTB_CFG_B_RUN] & tickB;
  assign wrap16 = joinMode & incB & matchB & matchC;
  assign clrB = joinMode ? wrap16 : (incB & matchB);
  assign incC = joinMode ? (incB & (counterB == 8'hff))
                         : (cfgR[`FTB_CFG_C_RUN] & tickC);
  assign clrC = joinMode ? wrap16 : (incC & matchC);

  ftb_period_timer u_counter_b (
    .mclk(mclk),
    .reset_n(reset_n),
    .inc(incB),
    .clr(clrB),
    .cntWr(wrB),
    .perWr(wrPerB),
    .wrData(wrByte),
    .count(counterB),
    .period(periodB),
    .atMatch(matchB)
  );

  ftb_period_timer u_counter_c (
    .mclk(mclk),
    .reset_n(reset_n),
    .inc(incC),
    .clr(clrC),
    .cntWr(wrC),
    .perWr(wrPerC),
    .wrData(wrByte),
    .count(counterC),
    .period(periodC),
    .atMatch(matchC)
  );

  // counter_d: period wrap, or free run while period_d captures
  assign capMode = cfgR[`FTB_CFG_CAP4];
  assign capRise = captureTwoPin & ~capPrevR;
  assign tickD = cfgR[`FTB_CFG_D_EXT] ? (counterDClockPin & ~dPinPrevR) : insnTick;
  assign incD = cfgR[`FTB_CFG_D_RUN] & tickD;
  assign wrapD = incD & (capMode ? (counterDR == 16'hffff) : (counterDR == periodDR));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counterDR <= 16'h0000;
    end else if (wrDLo) begin
      counterDR <= {counterDR[15:8], wrByte};
    end else if (wrDHi) begin
      counterDR <= {wrByte, counterDR[7:0]};
    end else if (wrapD) begin
      counterDR <= 16'h0000;
    end else if (incD) begin
      counterDR <= counterDR + 16'h0001;
    end
  end

  // period_d doubles as capture register in capture mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      periodDR <= `FTB_PER_D_RESET;
    end else if (capMode && capRise) begin
      periodDR <= counterDR;
    end else if (wrPerDLo) begin
      periodDR <= {periodDR[15:8], wrByte};
    end else if (wrPerDHi) begin
      periodDR <= {wrByte, periodDR[7:0]};
    end
  end

  // event flags: set wins over write-one-to-clear and vector ack
  assign flagSet[`FTB_FLG_A] = overflowA;
  assign flagSet[`FTB_FLG_EDGE] = ~srcInternal & t0Edge;
  assign flagSet[`FTB_FLG_INT] = timerZeroControlR[`FTB_CTRL_INT_EDGE] ?
    (extIntPin & ~intPrevR) : (~extIntPin & intPrevR);
  assign flagSet[`FTB_FLG_B] = joinMode ? wrap16 : (incB & matchB);
  assign flagSet[`FTB_FLG_C] = ~joinMode & incC & matchC;
  assign flagSet[`FTB_FLG_D] = wrapD;
  assign flagSet[`FTB_FLG_CAP] = capMode & capRise;
  assign flagClr = (wrFlags ? wrByte[6:0] : 7'h00) |
                   {6'h00, counterAVectorAck};
  assign flagsNxt = (flagsR & ~flagClr) | flagSet;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flagsR <= `FTB_FLG_RESET;
    end else begin
      flagsR <= flagsNxt;
    end
  end

  // masked request; each flag gated by its own enable
  assign intRequest = |(flagsR & enableR);

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence extTickSeq;
    psTick && !srcInternal ##1 !srcInternal [*3];
  endsequence

  a_ctrl_zero_bit: assert property (rdTake && regIdx == `FTB_IDX_CTRL
    |=> readdata[0] == 1'b0) else $error("control bit 0 read nonzero");
  a_a_overflow_flag: assert property (overflowA |=> flagsR[`FTB_FLG_A] &&
    counterALowR == 8'h00 && counterAHighR == 8'h00) else $error("counter_a wrap");
  a_a_ext_sync: assert property (extTickSeq |-> incA)
    else $error("external step lost after prescaler");
  a_a_int_source: assert property (srcInternal && incA |-> insnTick && !wrA)
    else $error("internal step off instruction clock");
  a_b_period_wrap: assert property (!joinMode && incB && matchB && !wrB
    |=> counterB == 8'h00 && flagsR[`FTB_FLG_B]) else $error("counter_b wrap");
  a_c_period_wrap: assert property (!joinMode && incC && matchC && !wrC
    |=> counterC == 8'h00 && flagsR[`FTB_FLG_C]) else $error("counter_c wrap");
  a_join_flag_b: assert property (wrap16 && !flagsR[`FTB_FLG_C]
    |=> flagsR[`FTB_FLG_B] && !flagsR[`FTB_FLG_C]) else $error("16-bit flag");
  a_d_period_wrap: assert property (wrapD && !wrDLo && !wrDHi
    |=> counterDR == 16'h0000 && flagsR[`FTB_FLG_D]) else $error("counter_d wrap");
  a_edge_flag: assert property (!srcInternal && t0Edge |=> flagsR[`FTB_FLG_EDGE])
    else $error("edge flag not set");
  a_ext_int_edge: assert property (timerZeroControlR[`FTB_CTRL_INT_EDGE] &&
    $rose(extIntPin) |=> flagsR[`FTB_FLG_INT]) else $error("int edge missed");
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest longer than one cycle");
endmodule // ftb_top

// ### tb/ftb_pin_model.sv
// Purpose: far-side model of the timer pins (clock, interrupt, capture inputs)
// Assumes: the block samples every pin on mclk
// Notes: a level only moves right after a rising edge
module ftb_pin_model (
  // clock
  input wire logic mclk,
  // pins toward the block: timer0, ext int, shared, d clock, capture
  output logic [4:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // all pins idle low
  initial pins = 5'h00;
  // one level change, held four cycles so the synchroniser sees it
  task automatic toggle(input int k);
    @(posedge mclk);
    pins[k] <= ~pins[k];
    repeat (3) @(posedge mclk);
  endtask
  // n full pulses: one rise and one fall each
  task automatic pulses(input int k, input int n);
    repeat (2 * n) toggle(k);
  endtask
endmodule // ftb_pin_model

// ### tb/tb_top.sv
// Purpose: self-checking bench for the four-timer block
// Assumes: one wait state per access; pins move only when pulsed
// Notes: a register model is updated on every write and every event
`include "ftb_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T0 = 0, EI = 1, SH = 2, DP = 3, CP = 4; // pin slots
  // clock, reset and bus drive
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] writedata = 32'h0;
  logic counterAVectorAck = 1'b0;
  wire logic [31:0] readdata;
  wire logic waitrequest;
  wire logic intRequest;
  wire logic [4:0] pins;
  // register model and tallies
  int mreg [64];
  int num_errors = 0;
  int check_count = 0;
  int unsigned seed = 53;
  // 125 MHz
  always #4 mclk = ~mclk;
  ftb_top ftb_top_i (.mclk(mclk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .timer0ClockPin(pins[0]), .extIntPin(pins[1]),
    .sharedExtClockPin(pins[2]), .counterDClockPin(pins[3]), .captureTwoPin(pins[4]),
    .counterAVectorAck(counterAVectorAck), .intRequest(intRequest));
  ftb_pin_model ftb_pin_model_i (.mclk(mclk), .pins(pins));
  // xorshift source, fixed start
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // verdict and end of run
  task automatic test_done();
    $display("mismatches %0d of %0d checks", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // exact value compare
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // range compare, for free-running counts
  task automatic chkRange(input string what, input int lo, input int hi,
                          input logic [31:0] got);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      num_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // one access; held until waitrequest is low at a rising edge
  task automatic bus(input bit wr, input int idx, input int d, output logic [31:0] q);
    int n;
    address <= 8'(idx * 4);
    writedata <= 32'(d);
    read <= !wr;
    write <= wr;
    q = 32'h0;
    // waitrequest and readdata still hold their pre-edge values when this wakes
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) begin
        q = readdata;
        break;
      end
    end
    read <= 1'b0;
    write <= 1'b0;
    // a slave that never answers ends the run
    if (n == 20) begin
      num_errors++;
      test_done();
    end
    @(posedge mclk);
  endtask
  // write, then mirror into the model; flags are write-one-to-clear
  task automatic wr(input int idx, input int d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
    if (byteenable[0] !== 1'b1) return;
    if (idx == `FTB_IDX_FLAGS) mreg[idx] &= ~d;
    else if (idx == `FTB_IDX_CTRL) mreg[idx] = d & 'hfe;
    else if (idx inside {`FTB_IDX_A_LO, `FTB_IDX_A_HI, [16:26]}) mreg[idx] = d & 'hff;
  endtask
  // read and compare with the model
  task automatic rd(input int idx);
    logic [31:0] q;
    bus(1'b0, idx, 0, q);
    chk($sformatf("reg %h", idx), 32'(mreg[idx]), q);
  endtask
  initial begin
    logic [31:0] q;
    int c, r, n, e, ed, st;
    mreg[`FTB_IDX_PER_B] = 'hff;
    mreg[`FTB_IDX_PER_C] = 'hff;
    mreg[`FTB_IDX_PER_D_LO] = 'hff;
    mreg[`FTB_IDX_PER_D_HI] = 'hff;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    // reset values; unmapped places read zero
    for (c = 0; c < 32; c++) rd(c);
    wr(`FTB_IDX_CTRL, 'hff);
    rd(`FTB_IDX_CTRL);
    // a write with lane 0 off must not land
    byteenable <= 4'h0;
    wr(`FTB_IDX_CTRL, 'h00);
    byteenable <= 4'h1;
    rd(`FTB_IDX_CTRL);
    wr(3, 'haa);
    rd(3);
    // counter_a: every prescale ratio, either edge, start near the top
    for (c = 0; c < 10; c++) begin
      r = 1 << (c > 8 ? 8 : c);
      n = 1 + rnd() % (2 * r);
      e = rnd() % 2;
      ed = rnd() % 2;
      st = 'hfffd + rnd() % 3;
      if (pins[T0]) ftb_pin_model_i.toggle(T0);
      wr(`FTB_IDX_CTRL, ed * 'h40 + c * 2);
      wr(`FTB_IDX_A_LO, st & 'hff);
      wr(`FTB_IDX_A_HI, st >> 8);
      wr(`FTB_IDX_FLAGS, 'h7f);
      ftb_pin_model_i.pulses(T0, n);
      // a lone rise counts only with rising select
      if (e) ftb_pin_model_i.toggle(T0);
      st += (n + e * ed) / r;
      mreg[`FTB_IDX_A_LO] = st & 'hff;
      mreg[`FTB_IDX_A_HI] = (st >> 8) & 'hff;
      mreg[`FTB_IDX_FLAGS] = 2 + (st > 'hffff ? 1 : 0);
      repeat (8) @(posedge mclk);
      rd(`FTB_IDX_A_LO);
      rd(`FTB_IDX_A_HI);
      rd(`FTB_IDX_FLAGS);
      // vector acknowledge drops only the overflow flag
      counterAVectorAck <= 1'b1;
      @(posedge mclk);
      counterAVectorAck <= 1'b0;
      mreg[`FTB_IDX_FLAGS] &= 'h7e;
      rd(`FTB_IDX_FLAGS);
    end
    // internal source: one step per four clocks
    wr(`FTB_IDX_CTRL, 'h20);
    wr(`FTB_IDX_A_LO, 0);
    wr(`FTB_IDX_A_HI, 0);
    repeat (400) @(posedge mclk);
    bus(1'b0, `FTB_IDX_A_LO, 0, q);
    chkRange("internal count", 98, 104, q);
    // ext int pin edge select, both settings
    for (c = 0; c < 2; c++) begin
      wr(`FTB_IDX_CTRL, c * 'h80);
      wr(`FTB_IDX_FLAGS, 'h7f);
      ftb_pin_model_i.toggle(EI);
      mreg[`FTB_IDX_FLAGS] = c * 4;
      rd(`FTB_IDX_FLAGS);
      ftb_pin_model_i.toggle(EI);
      mreg[`FTB_IDX_FLAGS] = 4;
      rd(`FTB_IDX_FLAGS);
    end
    // request follows flag and enable
    wr(`FTB_IDX_ENABLE, 'h04);
    rd(`FTB_IDX_ENABLE);
    chk("irq on", 32'd1, {31'h0, intRequest});
    wr(`FTB_IDX_ENABLE, 'h00);
    chk("irq off", 32'd0, {31'h0, intRequest});
    // shared pin into b, then c, then both joined as one 16-bit count
    for (c = 0; c < 3; c++) begin
      wr(`FTB_IDX_CFG, 0);
      wr(`FTB_IDX_PER_B, c == 2 ? 'hff : 5);
      wr(`FTB_IDX_PER_C, c == 2 ? 1 : 2);
      wr(`FTB_IDX_B, c == 2 ? 'hfe : 3);
      wr(`FTB_IDX_C, 1);
      wr(`FTB_IDX_FLAGS, 'h7f);
      wr(`FTB_IDX_CFG, c == 0 ? 'h05 : c == 1 ? 'h0a : 'h15);
      n = 2 + rnd() % 3;
      ftb_pin_model_i.pulses(SH, n);
      st = c == 0 ? 3 : c == 1 ? 1 : 'h1fe;
      r = c == 0 ? 5 : c == 1 ? 2 : 'h1ff;
      e = (st + n) % (r + 1);
      if (c != 1) mreg[`FTB_IDX_B] = e & 'hff;
      if (c != 0) mreg[`FTB_IDX_C] = e >> (c == 2 ? 8 : 0);
      mreg[`FTB_IDX_FLAGS] = st + n > r ? (c == 1 ? 16 : 8) : 0;
      repeat (8) @(posedge mclk);
      rd(`FTB_IDX_B);
      rd(`FTB_IDX_C);
      rd(`FTB_IDX_FLAGS);
    end
    // counter_d on its own pin, period 3
    wr(`FTB_IDX_CFG, 0);
    wr(`FTB_IDX_PER_D_LO, 3);
    wr(`FTB_IDX_PER_D_HI, 0);
    wr(`FTB_IDX_D_LO, 2);
    wr(`FTB_IDX_D_HI, 0);
    wr(`FTB_IDX_FLAGS, 'h7f);
    wr(`FTB_IDX_CFG, 'h60);
    ftb_pin_model_i.pulses(DP, 3);
    mreg[`FTB_IDX_D_LO] = 1;
    mreg[`FTB_IDX_FLAGS] = 32;
    repeat (8) @(posedge mclk);
    rd(`FTB_IDX_D_LO);
    rd(`FTB_IDX_D_HI);
    rd(`FTB_IDX_FLAGS);
    // capture mode: period_d takes the count on a rise
    wr(`FTB_IDX_CFG, 'he0);
    ftb_pin_model_i.toggle(CP);
    mreg[`FTB_IDX_PER_D_LO] = 1;
    repeat (4) @(posedge mclk);
    rd(`FTB_IDX_PER_D_LO);
    rd(`FTB_IDX_PER_D_HI);
    test_done();
  end
endmodule // tb_top
